// [common/rx_link_defs.svh]
/*
 * Constants of the receive data link extractor: register offsets,
 * reset values, destuffer run limits, frame timing.
 * Assumes the includer uses these as plain `define names.
 */
`ifndef RX_LINK_DEFS_SVH
`define RX_LINK_DEFS_SVH
`define RX_LINK_BYTE_ADDR    8'h28
`define LINK_MATCH_A_ADDR    8'h29
`define LINK_MATCH_B_ADDR    8'h2A
`define LINK_BYTE_RESET      8'h00
`define MATCH_BYTE_RESET     8'h00
`define STUFF_RUN            3'h5
`define ABORT_RUN            3'h6
`define LAST_BIT_INDEX       3'h7
`define FRAME_TIME_US        250
`define FRAMES_PER_BYTE      8
`endif

// [common/rx_link_pkg.sv]
/*
 * Types of the receive data link extractor.
 * Assumes rx_link_defs.svh is compiled alongside.
 */
package rx_link_pkg;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } host_req_type;

   typedef struct packed {
      logic line_bit;
      logic esf_dl_slot;
      logic fs_slot;
   } line_in_type;

   typedef struct packed {
      logic esf_framing_select;
      logic destuff_enable;
      logic rx_link_full_irq_mask;
      logic link_match_irq_mask;
   } link_ctrl_type;
endpackage : rx_link_pkg

// [src/rx_data_link_extractor.sv]
/*
 * Receive data link extractor with its bit FIFO.
 * Assumes line slots arrive synchronous to clock and the host port
 * is a synchronous 8-bit read/write strobe port.
 */
`include "rx_link_defs.svh"

module link_bit_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 4
) (
   input  wire logic             clock,
   input  wire logic             arst_n,
   input  wire logic             ce,
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   output logic                  out_valid,
   output logic      [WIDTH-1:0] out_data,
   input  wire logic             out_ready
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [PW-1:0]    wr_ptr_ff;
   logic [PW-1:0]    rd_ptr_ff;
   logic [CW-1:0]    count_ff;
   wire              push = in_valid & in_ready;
   wire              pop  = out_valid & out_ready;

   assign in_ready  = (count_ff != CW'(DEPTH));
   assign out_valid = (count_ff != '0);
   assign out_data  = mem_ff[rd_ptr_ff];

   // power-of-two depth assumed so pointers wrap naturally
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff  <= '0;
      end else if (ce) begin
         if (push) wr_ptr_ff <= wr_ptr_ff + PW'(1);
         if (pop) rd_ptr_ff <= rd_ptr_ff + PW'(1);
         count_ff <= count_ff + CW'(push) - CW'(pop);
      end
   end

   always_ff @(posedge clock) begin
      if (ce && push) mem_ff[wr_ptr_ff] <= in_data;
   end
endmodule : link_bit_fifo

module rx_data_link_extractor #(
   parameter int FIFO_DEPTH = 4
) (
   input  wire logic                       clock,
   input  wire logic                       arst_n,
   input  wire logic                       ce,
   input  wire rx_link_pkg::line_in_type   line_in,
   input  wire rx_link_pkg::host_req_type  host_req,
   input  wire rx_link_pkg::link_ctrl_type ctrl,
   input  wire logic                       clear_full,
   input  wire logic                       clear_match,
   output logic [7:0]                      rdata_ff,
   output logic                            rx_link_full_flag_ff,
   output logic                            link_match_flag_ff,
   output logic                            second_irq_n_ff,
   output logic                            link_ready_ff
);
   logic [7:0] shift_ff;
   logic [2:0] bit_cnt_ff;
   logic [2:0] ones_cnt_ff;
   logic [7:0] rx_link_byte_ff;
   logic [7:0] link_match_byte_a_ff;
   logic [7:0] link_match_byte_b_ff;
   logic       fifo_ready;
   logic       fifo_out_valid;
   logic [0:0] fifo_out_data;
   logic       xfer_hold_ff;

   // slot selection by framing mode
   wire        src_valid = ctrl.esf_framing_select ? line_in.esf_dl_slot
                                                   : line_in.fs_slot;
   wire        drop_bit  = ctrl.destuff_enable & ~line_in.line_bit
                           & (ones_cnt_ff == `STUFF_RUN);
   wire        fifo_push = src_valid & ~drop_bit;
   wire        fifo_pop  = fifo_out_valid & ~xfer_hold_ff;
   wire        byte_done = fifo_pop & (bit_cnt_ff == `LAST_BIT_INDEX);
   wire [7:0]  nxt_shift = {fifo_out_data[0], shift_ff[7:1]};
   wire        match_hit = (nxt_shift == link_match_byte_a_ff)
                           | (nxt_shift == link_match_byte_b_ff);
   wire        rd_byte   = host_req.rd & (host_req.addr == `RX_LINK_BYTE_ADDR);
   wire        rd_ma     = host_req.rd & (host_req.addr == `LINK_MATCH_A_ADDR);
   wire        rd_mb     = host_req.rd & (host_req.addr == `LINK_MATCH_B_ADDR);
   wire        wr_ma     = host_req.wr & (host_req.addr == `LINK_MATCH_A_ADDR);
   wire        wr_mb     = host_req.wr & (host_req.addr == `LINK_MATCH_B_ADDR);
   wire [7:0]  nxt_rdata = rd_byte ? rx_link_byte_ff
                         : rd_ma   ? link_match_byte_a_ff
                         : rd_mb   ? link_match_byte_b_ff
                         : 8'h00;
   // set wins over a clear arriving in the same cycle
   wire        nxt_full  = byte_done | (rx_link_full_flag_ff & ~clear_full);
   wire        nxt_match = (byte_done & match_hit)
                           | (link_match_flag_ff & ~clear_match);
   wire        nxt_irq_n = ~((rx_link_full_flag_ff & ctrl.rx_link_full_irq_mask)
                           | (link_match_flag_ff & ctrl.link_match_irq_mask));
   wire [2:0]  nxt_ones  = ~line_in.line_bit ? 3'h0
                         : (ones_cnt_ff == `ABORT_RUN) ? `ABORT_RUN
                         : ones_cnt_ff + 3'h1;

   link_bit_fifo #(
      .WIDTH (1),
      .DEPTH (FIFO_DEPTH)
   ) link_bit_fifo_inst (
      .clock     (clock),
      .arst_n    (arst_n),
      .ce        (ce),
      .in_valid  (fifo_push),
      .in_data   (line_in.line_bit),
      .in_ready  (fifo_ready),
      .out_valid (fifo_out_valid),
      .out_data  (fifo_out_data),
      .out_ready (~xfer_hold_ff)
   );

   // destuffer run counter watches every selected slot
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) ones_cnt_ff <= 3'h0;
      else if (ce && src_valid) ones_cnt_ff <= nxt_ones;
   end

   // drain stalls one cycle after each byte so the copy settles
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         shift_ff     <= `LINK_BYTE_RESET;
         bit_cnt_ff   <= 3'h0;
         xfer_hold_ff <= 1'b0;
      end else if (ce) begin
         xfer_hold_ff <= byte_done;
         if (fifo_pop) begin
            shift_ff   <= nxt_shift;
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
         end
      end
   end

   // whole byte copied at once; older byte is lost if unread
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) rx_link_byte_ff <= `LINK_BYTE_RESET;
      else if (ce && byte_done) rx_link_byte_ff <= nxt_shift;
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         link_match_byte_a_ff <= `MATCH_BYTE_RESET;
         link_match_byte_b_ff <= `MATCH_BYTE_RESET;
      end else if (ce) begin
         if (wr_ma) link_match_byte_a_ff <= host_req.wdata;
         if (wr_mb) link_match_byte_b_ff <= host_req.wdata;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rdata_ff             <= 8'h00;
         rx_link_full_flag_ff <= 1'b0;
         link_match_flag_ff   <= 1'b0;
         second_irq_n_ff      <= 1'b1;
         link_ready_ff        <= 1'b0;
      end else if (ce) begin
         rdata_ff             <= nxt_rdata;
         rx_link_full_flag_ff <= nxt_full;
         link_match_flag_ff   <= nxt_match;
         second_irq_n_ff      <= nxt_irq_n;
         link_ready_ff        <= fifo_ready;
      end
   end

   slot_select_a: assert property (@(posedge clock) disable iff (!arst_n)
      src_valid == (ctrl.esf_framing_select ? line_in.esf_dl_slot : line_in.fs_slot))
      else $error("slot selection does not follow framing mode");

   lsb_first_a: assert property (@(posedge clock) disable iff (!arst_n)
      (ce && byte_done) |=> rx_link_byte_ff[7] == $past(fifo_out_data[0]))
      else $error("last bit did not land in msb");

   byte_copy_a: assert property (@(posedge clock) disable iff (!arst_n)
      (ce && byte_done) |=> rx_link_byte_ff[6:0] == $past(shift_ff[7:1], 1))
      else $error("byte register not loaded from shifter");

   byte_count_a: assert property (@(posedge clock) disable iff (!arst_n)
      (ce && byte_done) |=> bit_cnt_ff == 3'h0 && xfer_hold_ff)
      else $error("byte completed off an eight bit boundary");

   full_set_a: assert property (@(posedge clock) disable iff (!arst_n)
      (ce && byte_done) |=> rx_link_full_flag_ff)
      else $error("full flag not set on completed byte");

   match_set_a: assert property (@(posedge clock) disable iff (!arst_n)
      (ce && byte_done && match_hit) |=> link_match_flag_ff)
      else $error("match flag not set on equal byte");

   irq_full_a: assert property (@(posedge clock) disable iff (!arst_n)
      (ce && rx_link_full_flag_ff && ctrl.rx_link_full_irq_mask) |=> !second_irq_n_ff)
      else $error("full interrupt not asserted");

   irq_match_a: assert property (@(posedge clock) disable iff (!arst_n)
      (ce && link_match_flag_ff && ctrl.link_match_irq_mask) |=> !second_irq_n_ff)
      else $error("match interrupt not asserted");

   irq_quiet_a: assert property (@(posedge clock) disable iff (!arst_n)
      (ce && !(rx_link_full_flag_ff && ctrl.rx_link_full_irq_mask)
          && !(link_match_flag_ff && ctrl.link_match_irq_mask)) |=> second_irq_n_ff)
      else $error("interrupt asserted while masked");

   destuff_drop_a: assert property (@(posedge clock) disable iff (!arst_n)
      (src_valid && ctrl.destuff_enable && !line_in.line_bit
         && ones_cnt_ff == 3'h5) |-> !fifo_push)
      else $error("stuffed zero not removed");

   abort_keep_a: assert property (@(posedge clock) disable iff (!arst_n)
      (src_valid && !line_in.line_bit && ones_cnt_ff == 3'h6) |-> fifo_push)
      else $error("zero after six ones removed");

   read_byte_a: assert property (@(posedge clock) disable iff (!arst_n)
      (ce && rd_byte) |=> rdata_ff == $past(rx_link_byte_ff))
      else $error("received byte read returned wrong value");

   match_write_a: assert property (@(posedge clock) disable iff (!arst_n)
      (ce && wr_mb) |=> link_match_byte_b_ff == $past(host_req.wdata))
      else $error("match byte write lost");
endmodule : rx_data_link_extractor

// [verification/line_stream_model.sv]
/*
 * Model of the recovered line stream feeding the link extractor.
 * Assumes the bench pushes bits and drives esf_sel as the design's select.
 */
module line_stream_model (
   input  wire logic               clock,
   input  wire logic               esf_sel,
   input  wire logic               link_ready,
   output rx_link_pkg::line_in_type line_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic q[$];
   logic last = 1'b0;
   logic gap  = 1'b0;
   logic nb, ne, nf;

   task automatic push(input logic [15:0] v, input int n);
      for (int i = 0; i < n; i++) q.push_back(v[i]);
   endtask : push

   initial line_in = '0;
   // outside a slot the bit line shows the inverse, never a stale value
   always @(posedge clock) begin
      #1;
      nb = ~last;
      ne = 1'b0;
      nf = 1'b0;
      if (q.size() > 0 && link_ready && !gap) begin
         last = q.pop_front();
         nb = last;
         ne = esf_sel;
         nf = ~esf_sel;
         gap = 1'b1;
      end else if (gap) begin
         // decoy strobe on the unselected slot
         ne = ~esf_sel;
         nf = esf_sel;
         gap = 1'b0;
      end
      line_in = '{line_bit: nb, esf_dl_slot: ne, fs_slot: nf};
   end
endmodule : line_stream_model

// [verification/rx_data_link_extractor_tb.sv]
/*
 * Self-checking bench of the receive link extractor.
 * Assumes the design files and line_stream_model are compiled first.
 */
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module rx_data_link_extractor_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic                        clock = 1'b0;
   logic                        arst_n = 1'b0;
   logic                        ce = 1'b1;
   rx_link_pkg::host_req_type   hr = '0;
   rx_link_pkg::link_ctrl_type  ctl = '0;
   rx_link_pkg::line_in_type    line_in;
   logic                        clear_full = 1'b0;
   logic                        clear_match = 1'b0;
   logic [7:0]                  rdata, v;
   logic                        full, match, irq_n, ready;
   int                          n_errors = 0;
   int                          checked = 0;
   logic [7:0]                  mv[2] = '{8'h3C, 8'hC3};

   always #5 clock = ~clock;

   rx_data_link_extractor rx_data_link_extractor_inst (.clock(clock), .arst_n(arst_n),
      .ce(ce), .line_in(line_in), .host_req(hr), .ctrl(ctl), .clear_full(clear_full),
      .clear_match(clear_match), .rdata_ff(rdata), .rx_link_full_flag_ff(full),
      .link_match_flag_ff(match), .second_irq_n_ff(irq_n), .link_ready_ff(ready));
   line_stream_model line_stream_model_inst (.clock(clock), .esf_sel(ctl.esf_framing_select),
      .link_ready(ready), .line_in(line_in));

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock) #1 hr = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clock) #1 hr = '0;
      d = rdata;
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock) #1 hr = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clock) #1 hr = '0;
   endtask : wr
   task automatic clr();
      @(posedge clock) #1 {clear_full, clear_match} = 2'b11;
      @(posedge clock) #1 {clear_full, clear_match} = 2'b00;
      repeat (2) @(posedge clock);
      #1;
   endtask : clr
   // host waits for the full flag after each byte, giving up after 400 clocks
   task automatic get_byte(input logic [15:0] b, input int n);
      line_stream_model_inst.push(b, n);
      for (int i = 0; i < 400; i++) begin
         @(posedge clock) #1;
         if (full === 1'b1) break;
      end
      `CHK(full, 1'b1)
      @(posedge clock) #1;
   endtask : get_byte
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : summarize

   initial begin
      #100us;
      n_errors++;
      summarize();
   end

   initial begin
      repeat (12) @(posedge clock);
      #1 arst_n = 1'b1;
      `CHK(ready, 1'b0)
      rd(8'h28, v);
      `CHK(v, 8'h00)
      rd(8'h29, v);
      `CHK(v, 8'h00)
      `CHK(ready, 1'b1)
      `CHK(irq_n, 1'b1)
      $display("test reset done");
      ctl.esf_framing_select = 1'b1;
      get_byte(16'hA5, 8);
      `CHK(irq_n, 1'b1)
      `CHK(match, 1'b0)
      rd(8'h28, v);
      `CHK(v, 8'hA5)
      wr(8'h28, 8'hFF);
      rd(8'h28, v);
      `CHK(v, 8'hA5)
      rd(8'h30, v);
      `CHK(v, 8'h00)
      clr();
      `CHK(full, 1'b0)
      ctl.rx_link_full_irq_mask = 1'b1;
      get_byte(16'h81, 8);
      `CHK(irq_n, 1'b0)
      rd(8'h28, v);
      `CHK(v, 8'h81)
      ctl = '{esf_framing_select: 1'b1, link_match_irq_mask: 1'b1, default: 1'b0};
      clr();
      `CHK(irq_n, 1'b1)
      $display("test esf byte done");
      wr(8'h29, mv[0]);
      wr(8'h2A, mv[1]);
      rd(8'h2A, v);
      `CHK(v, mv[1])
      rd(8'h29, v);
      `CHK(v, mv[0])
      foreach (mv[i]) begin
         clr();
         get_byte({8'h00, mv[i]}, 8);
         `CHK(match, 1'b1)
         `CHK(irq_n, 1'b0)
      end
      clr();
      get_byte(16'h3D, 8);
      `CHK(match, 1'b0)
      `CHK(irq_n, 1'b1)
      $display("test match done");
      ctl.esf_framing_select = 1'b0;
      clr();
      // five ones then a zero must pass while destuffing is off
      get_byte(16'h5F, 8);
      rd(8'h28, v);
      `CHK(v, 8'h5F)
      $display("test superframe done");
      ctl = '{esf_framing_select: 1'b1, destuff_enable: 1'b1, default: 1'b0};
      clr();
      get_byte(16'h05F, 9);
      rd(8'h28, v);
      `CHK(v, 8'h3F)
      clr();
      get_byte(16'hBF, 8);
      rd(8'h28, v);
      `CHK(v, 8'hBF)
      $display("test destuff done");
      // frozen block ignores both the write and the clear pulses
      ce = 1'b0;
      wr(8'h29, 8'h11);
      clr();
      ce = 1'b1;
      `CHK(full, 1'b1)
      rd(8'h29, v);
      `CHK(v, mv[0])
      $display("test clock enable done");
      summarize();
   end
endmodule : rx_data_link_extractor_tb
